// ### rtl/aoi_frame_timing_pkg.sv
package aoi_frame_timing_pkg;
    // sensor geometry
    localparam int SENSOR_LINES   = 1083;
    localparam int OB_LINES       = 4;
    localparam int DUMP_GROUP     = 4;
    // frame tail constants per case
    localparam int TAIL_B1_LOW    = 29;
    localparam int TAIL_B1_HIGH   = 28;
    localparam int TAIL_B2_LOW    = 25;
    localparam int TAIL_B2_HIGH   = 23;
    // line periods in nanoseconds and in clock cycles
    localparam int CLOCK_NS       = 8;
    localparam int LINE_NS_BIN1   = 23540;
    localparam int LINE_NS_BIN2   = 25670;
    localparam int LINE_CYC_BIN1  = LINE_NS_BIN1 / CLOCK_NS;
    localparam int LINE_CYC_BIN2  = LINE_NS_BIN2 / CLOCK_NS;
    // binning mode encoding
    localparam logic [1:0] BIN_OFF = 2'h0;
    localparam logic [1:0] BIN_2X1 = 2'h1;
    localparam logic [1:0] BIN_1X2 = 2'h2;
    localparam logic [1:0] BIN_2X2 = 2'h3;
    localparam int BIN_VERT_BIT   = 1;
endpackage

// ### rtl/aoi_frame_line_timing.sv
module aoi_frame_line_timing #(
    parameter int W  = 11,
    parameter int CW = 12
) (
    input  wire logic          clock,
    input  wire logic          reset,
    input  wire logic          enable,
    input  wire logic [W-1:0]  aoi_vertical_offset,
    input  wire logic [W-1:0]  aoi_height,
    input  wire logic [1:0]    binning_mode,
    output logic               line_start,
    output logic               frame_start,
    output logic [CW-1:0]      line_index,
    output logic [CW-1:0]      frame_lines,
    output logic [CW-1:0]      line_period_cycles,
    output logic               line_active,
    output logic               ob_line,
    output logic               vertical_bin2
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CALC = 3'b010,
        ST_RUN  = 3'b100
    } st_t;

    typedef struct packed {
        st_t           st;
        logic [W-1:0]  off;
        logic [W-1:0]  hgt;
        logic          vbin2;
        logic [CW-1:0] lines;
        logic [CW-1:0] period;
        logic [CW-1:0] cyc;
        logic [CW-1:0] idx;
        logic          line_start;
        logic          frame_start;
        logic          active;
        logic          ob;
    } state_t;

    localparam logic [CW-1:0] CYC1 = CW'(aoi_frame_timing_pkg::LINE_CYC_BIN1);
    localparam logic [CW-1:0] CYC2 = CW'(aoi_frame_timing_pkg::LINE_CYC_BIN2);
    localparam logic [CW-1:0] ONE  = CW'(1);

    state_t q;
    state_t d;
    logic   in_vbin2;

    // frame line count for a setting
    function automatic logic [CW-1:0] calc_lines(input logic [W-1:0] o, input logic [W-1:0] h,
                                                 input logic v2);
        int so;
        int sh;
        int r;
        so = int'(o);
        sh = int'(h);
        if (!v2 && so < aoi_frame_timing_pkg::OB_LINES) begin
            r = ((aoi_frame_timing_pkg::SENSOR_LINES - (sh + so - aoi_frame_timing_pkg::OB_LINES))
                 >>> 2) + sh - (aoi_frame_timing_pkg::OB_LINES - so)
                + aoi_frame_timing_pkg::TAIL_B1_LOW;
        end else if (!v2) begin
            r = ((so + aoi_frame_timing_pkg::DUMP_GROUP - 1) / aoi_frame_timing_pkg::DUMP_GROUP)
                + ((aoi_frame_timing_pkg::SENSOR_LINES - (sh + so - aoi_frame_timing_pkg::OB_LINES))
                 >>> 2) + sh + aoi_frame_timing_pkg::TAIL_B1_HIGH;
        end else if (so < aoi_frame_timing_pkg::OB_LINES) begin
            r = ((aoi_frame_timing_pkg::SENSOR_LINES
                  - ((sh - (aoi_frame_timing_pkg::OB_LINES - so)) * 2
                     + (so * 2 - aoi_frame_timing_pkg::OB_LINES))) >>> 2)
                + sh - (aoi_frame_timing_pkg::OB_LINES - so)
                + aoi_frame_timing_pkg::TAIL_B2_LOW;
        end else begin
            r = ((so + 1) / 2)
                + ((aoi_frame_timing_pkg::SENSOR_LINES
                    - (sh * 2 + (so * 2 - aoi_frame_timing_pkg::OB_LINES))) >>> 2)
                + sh + aoi_frame_timing_pkg::TAIL_B2_HIGH;
        end
        if (r < 1) begin
            r = 1;
        end
        if (r > (1 << CW) - 1) begin
            r = (1 << CW) - 1;
        end
        return r[CW-1:0];
    endfunction

    assign in_vbin2 = binning_mode[aoi_frame_timing_pkg::BIN_VERT_BIT];

    always_comb begin
        d             = q;
        d.line_start  = 1'b0;
        d.frame_start = 1'b0;
        case (q.st)
            ST_IDLE: begin
                d.cyc = '0;
                d.idx = '0;
                if (enable) begin
                    d.off   = aoi_vertical_offset;
                    d.hgt   = aoi_height;
                    d.vbin2 = in_vbin2;
                    d.st    = ST_CALC;
                end
            end
            ST_CALC: begin
                d.lines       = calc_lines(q.off, q.hgt, q.vbin2);
                d.period      = q.vbin2 ? CYC2 : CYC1;
                d.cyc         = '0;
                d.idx         = '0;
                d.line_start  = 1'b1;
                d.frame_start = 1'b1;
                d.st          = ST_RUN;
            end
            ST_RUN: begin
                if (!enable) begin
                    d.st = ST_IDLE;
                end else if (aoi_vertical_offset != q.off || aoi_height != q.hgt
                             || in_vbin2 != q.vbin2) begin
                    d.off   = aoi_vertical_offset;
                    d.hgt   = aoi_height;
                    d.vbin2 = in_vbin2;
                    d.st    = ST_CALC;
                end else if (q.cyc >= q.period - ONE) begin
                    d.cyc        = '0;
                    d.line_start = 1'b1;
                    if (q.idx >= q.lines - ONE) begin
                        d.idx         = '0;
                        d.frame_start = 1'b1;
                    end else begin
                        d.idx = q.idx + ONE;
                    end
                end else begin
                    d.cyc = q.cyc + ONE;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
        d.active = (d.st == ST_RUN) && (d.idx < CW'(d.hgt));
        d.ob     = d.active && (CW'(d.off) + d.idx < CW'(aoi_frame_timing_pkg::OB_LINES));
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            q        <= '0;
            q.st     <= ST_IDLE;
            q.period <= CYC1;
            q.lines  <= ONE;
        end else begin
            q <= d;
        end
    end

    assign line_start         = q.line_start;
    assign frame_start        = q.frame_start;
    assign line_index         = q.idx;
    assign frame_lines        = q.lines;
    assign line_period_cycles = q.period;
    assign line_active        = q.active;
    assign ob_line            = q.ob;
    assign vertical_bin2      = q.vbin2;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    property p_b1_low;
        q.st == ST_RUN && !q.vbin2 && q.off < W'(4) && q.hgt == W'(540)
            |-> q.lines == CW'(((1083 - (540 + int'(q.off) - 4)) >>> 2) + 540 - (4 - int'(q.off)) + 29);
    endproperty
    a_b1_low: assert property (p_b1_low) else $error("bin1 low-offset frame length wrong");

    property p_b1_high;
        q.st == ST_RUN && !q.vbin2 && q.off == W'(274) && q.hgt == W'(540) |-> q.lines == CW'(705);
    endproperty
    a_b1_high: assert property (p_b1_high) else $error("bin1 high-offset frame length wrong");

    property p_period1;
        q.st == ST_RUN && !q.vbin2 |-> q.period == CW'(2942);
    endproperty
    a_period1: assert property (p_period1) else $error("bin1 line period wrong");

    property p_bin_map;
        q.st == ST_CALC |=> q.vbin2 == $past(q.vbin2) && q.period == ($past(q.vbin2) ? CYC2 : CYC1);
    endproperty
    a_bin_map: assert property (p_bin_map) else $error("bin factor period mismatch");

    property p_b2_high;
        q.st == ST_RUN && q.vbin2 && q.off == W'(8) && q.hgt == W'(100) |-> q.lines == CW'(344);
    endproperty
    a_b2_high: assert property (p_b2_high) else $error("bin2 high-offset frame length wrong");

    property p_b2_low;
        q.st == ST_RUN && q.vbin2 && q.off == W'(0) && q.hgt == W'(100) |-> q.lines == CW'(344);
    endproperty
    a_b2_low: assert property (p_b2_low) else $error("bin2 low-offset frame length wrong");

    property p_period2;
        q.st == ST_RUN && q.vbin2 |-> q.period == CW'(3208);
    endproperty
    a_period2: assert property (p_period2) else $error("bin2 line period wrong");

    property p_ob;
        ob_line |-> line_active && CW'(q.off) + q.idx < CW'(4);
    endproperty
    a_ob: assert property (p_ob) else $error("optical-black flag outside top rows");

    property p_wrap;
        frame_start |-> line_start && q.idx == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("frame start without line zero");

    // restarts through the compute state are exempt
    property p_gap;
        line_start && $past(q.st) == ST_RUN |-> $past(q.cyc) == q.period - ONE;
    endproperty
    a_gap: assert property (p_gap) else $error("line start off the period count");
endmodule

// ### bench/line_sink.sv
module line_sink (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        line_start,
    output logic [11:0]      gap
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] count_q;
    // readout side: cycles between line starts
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count_q <= 12'h001;
            gap     <= 12'h000;
        end else if (line_start) begin
            count_q <= 12'h001;
            gap     <= count_q;
        end else begin
            count_q <= count_q + 12'h001;
        end
    end
endmodule

// ### bench/aoi_frame_line_timing_tb.sv
module aoi_frame_line_timing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        enable = 1'b0;
    logic [10:0] offs = 11'h000;
    logic [10:0] hgt = 11'h064;
    logic [1:0]  mode = 2'h0;
    logic        line_start, frame_start, line_active, ob_line, vertical_bin2;
    logic [11:0] line_index, frame_lines, line_period_cycles, gap;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          seed = 90775;
    int          cycles = 0;
    int          o, h, e, n, pe;
    int          fo[6] = '{274, 408, 476, 2, 8, 0};
    int          fh[6] = '{540, 270, 134, 540, 100, 100};
    int          fm[6] = '{0, 1, 0, 0, 2, 3};
    int          fx[6] = '{705, 502, 400, 703, 344, 344};
    always #4 clock = ~clock;
    aoi_frame_line_timing DUT (.clock(clock), .reset(reset), .enable(enable), .aoi_vertical_offset(offs),
        .aoi_height(hgt), .binning_mode(mode), .line_start(line_start), .frame_start(frame_start),
        .line_index(line_index), .frame_lines(frame_lines), .line_period_cycles(line_period_cycles),
        .line_active(line_active), .ob_line(ob_line), .vertical_bin2(vertical_bin2));
    line_sink sink (.clock(clock), .reset(reset), .line_start(line_start), .gap(gap));
    function automatic int fd4(int a);
        return (a >= 0) ? a / 4 : -((3 - a) / 4);
    endfunction
    function automatic int model(int o, int h, bit v2);
        int r;
        if (!v2 && o < 4) r = fd4(1083 - (h + o - 4)) + h - (4 - o) + 29;
        else if (!v2) r = (o + 3) / 4 + fd4(1083 - (h + o - 4)) + h + 28;
        else if (o < 4) r = fd4(1083 - ((h - (4 - o)) * 2 + (o * 2 - 4))) + h - (4 - o) + 25;
        else r = (o + 1) / 2 + fd4(1083 - (h * 2 + (o * 2 - 4))) + h + 23;
        return (r < 1) ? 1 : ((r > 4095) ? 4095 : r);
    endfunction
    task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wait_pulse(bit frm, int lim);
        n = 0;
        do begin
            @(posedge clock);
            #1 n++;
        end while ((frm ? frame_start : line_start) !== 1'b1 && n < lim);
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        repeat (20) @(posedge clock);
        #1 check("reset_frame_lines", frame_lines, 12'h001);
        check("reset_period", line_period_cycles, 12'h0b7e);
        @(posedge clock);
        reset <= 1'b0;
        enable <= 1'b1;
        wait_pulse(1'b1, 8);
        check("first_frame", frame_lines, 12'(model(0, 100, 1'b0)));
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            o = (i < 4) ? ($random(seed) & 3) : 4 + (($random(seed) & 32'h7fff_ffff) % 300);
            h = 101 + (($random(seed) & 32'h7fff_ffff) % 700);
            pe = i[1] ? 3208 : 2942;
            @(posedge clock);
            offs <= 11'(o);
            hgt <= 11'(h);
            mode <= 2'(i);
            wait_pulse(1'b1, 8);
            check("frame_start", {11'h000, frame_start}, 12'h001);
            e = model(o, h, i[1]);
            if (i[1]) check("frame_lines", frame_lines, 12'(e));
            else check("frame_lines", frame_lines, 12'(e));
            check("bin2", {11'h000, vertical_bin2}, {11'h000, i[1]});
            check("period", line_period_cycles, 12'(pe));
            check("index0", line_index, 12'h000);
            check("ob_line", {11'h000, ob_line}, {11'h000, o < 4});
            check("active", {11'h000, line_active}, 12'h001);
            wait_pulse(1'b0, 4000);
            check("index1", line_index, 12'h001);
            check("ob_line1", {11'h000, ob_line}, {11'h000, o < 3});
            @(posedge clock);
            #1 check("gap", gap, 12'(pe));
            $display("case %0d done", i);
        end
        for (int k = 0; k < 6; k++) begin
            @(posedge clock);
            offs <= 11'(fo[k]);
            hgt <= 11'(fh[k]);
            mode <= 2'(fm[k]);
            wait_pulse(1'b1, 8);
            check("doc_frame_lines", frame_lines, 12'(fx[k]));
            check("model_frame_lines", frame_lines, 12'(model(fo[k], fh[k], fm[k] > 1)));
            check("doc_period", line_period_cycles, (fm[k] > 1) ? 12'h0c88 : 12'h0b7e);
            $display("fixed case %0d done", k);
        end
        @(posedge clock);
        enable <= 1'b0;
        repeat (3) @(posedge clock);
        #1 check("idle_index", line_index, 12'h000);
        check("idle_line", {11'h000, line_start}, 12'h000);
        check("idle_active", {11'h000, line_active}, 12'h000);
        $display("idle test done");
        close_out();
    end
endmodule
